// file: common/imp_defs.vh
`ifndef IMP_DEFS_VH
`define IMP_DEFS_VH
// instruction forms
`define IMP_FORM_MPY3     3'h0
`define IMP_FORM_MPY_ADD  3'h1
`define IMP_FORM_MPY_SUB  3'h2
`define IMP_FORM_MPY_STO  3'h3
`define IMP_FORM_NEGATE_WITH_BORROW     3'h4
// three-operand mode field values
`define IMP_T_REG_REG     2'h0
`define IMP_T_IND_REG     2'h1
`define IMP_T_REG_IND     2'h2
`define IMP_T_IND_IND     2'h3
// general mode field values
`define IMP_G_REG         2'h0
`define IMP_G_DIRECT      2'h1
`define IMP_G_INDIRECT    2'h2
`define IMP_G_IMMEDIATE   2'h3
// parallel routing field values
`define IMP_P_0           2'h0
`define IMP_P_1           2'h1
`define IMP_P_2           2'h2
`define IMP_P_3           2'h3
// register limits
`define IMP_REG_MAX       5'h1b
`define IMP_PAR_REG_MAX   5'h07
// product destinations and sum destinations
`define IMP_PROD_DEST0    5'h00
`define IMP_SUM_DEST0     5'h02
// field positions
`define IMP_OPND_MSB      23
`define IMP_RES_MSB       31
`define IMP_PROD_MSB      47
// reset values
`define IMP_RST_WORD      32'h0000_0000
`define IMP_RST_IDX       5'h00
`endif

// file: hw/imp_datapath.v
`include "imp_defs.vh"
`default_nettype none
module imp_datapath (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // instruction issue
  input  wire        issue,
  input  wire [2:0]  form,
  input  wire [1:0]  mode,
  input  wire        product_dest_select,
  input  wire        sum_dest_select,
  input  wire [4:0]  dst_idx,
  input  wire [4:0]  src1_idx,
  input  wire [4:0]  src2_idx,
  input  wire [4:0]  src3_idx,
  input  wire [4:0]  src4_idx,
  // operand values sampled at start of execute
  input  wire [31:0] src1_reg,
  input  wire [31:0] src2_reg,
  input  wire [31:0] src3_reg,
  input  wire [31:0] src4_reg,
  input  wire [31:0] mem_a,
  input  wire [31:0] mem_b,
  input  wire [31:0] gen_direct,
  input  wire [31:0] gen_immediate,
  // status in
  input  wire        overflow_mode_bit,
  input  wire        carry_in,
  input  wire        latched_overflow_in,
  input  wire        latched_underflow_in,
  // register write results
  output reg         wr1_en,
  output reg  [4:0]  wr1_idx,
  output reg  [31:0] wr1_data,
  output reg         wr2_en,
  output reg  [4:0]  wr2_idx,
  output reg  [31:0] wr2_data,
  // store to memory
  output reg         store_en,
  output reg  [31:0] store_data,
  // status out
  output reg         flags_valid,
  output reg         neg_flag,
  output reg         zero_flag,
  output reg         overflow_flag,
  output reg         carry_flag,
  output reg         underflow_flag,
  output reg         latched_overflow_flag,
  output reg         latched_underflow_flag,
  output reg         bad_operands
);
  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  reg  [31:0] mul_a;
  reg  [31:0] mul_b;
  reg  [31:0] as_a;
  reg  [31:0] as_b;
  reg  [31:0] neg_src;
  reg         legal;
  wire [31:0] prod_low;
  wire        prod_ovf;
  // indirect operands come from memory ports a and b in order
  always @* begin
    mul_a   = src1_reg;
    mul_b   = src2_reg;
    as_a    = src1_reg;
    as_b    = src2_reg;
    neg_src = src1_reg;
    legal   = 1'b1;
    case (form)
      `IMP_FORM_MPY3: begin
        case (mode)
          `IMP_T_REG_REG: begin
            mul_a = src1_reg;
            mul_b = src2_reg;
          end
          `IMP_T_IND_REG: begin
            mul_a = mem_a;
            mul_b = src2_reg;
          end
          `IMP_T_REG_IND: begin
            mul_a = src1_reg;
            mul_b = mem_b;
          end
          default: begin
            mul_a = mem_a;
            mul_b = mem_b;
          end
        endcase
        legal = (dst_idx <= `IMP_REG_MAX) &&
                (mode[0] || src1_idx <= `IMP_REG_MAX) &&
                (mode[1] || src2_idx <= `IMP_REG_MAX);
      end
      `IMP_FORM_MPY_ADD, `IMP_FORM_MPY_SUB: begin
        // mem_a and mem_b are the indirect operands
        case (mode)
          `IMP_P_0: begin
            mul_a = mem_a;
            mul_b = mem_b;
            as_a  = src1_reg;
            as_b  = src2_reg;
          end
          `IMP_P_1: begin
            mul_a = mem_a;
            mul_b = src1_reg;
            as_a  = mem_b;
            as_b  = src2_reg;
          end
          `IMP_P_2: begin
            mul_a = src1_reg;
            mul_b = src2_reg;
            as_a  = mem_a;
            as_b  = mem_b;
          end
          default: begin
            mul_a = mem_a;
            mul_b = src1_reg;
            as_a  = src2_reg;
            as_b  = mem_b;
          end
        endcase
        legal = (src1_idx <= `IMP_PAR_REG_MAX) &&
                (src2_idx <= `IMP_PAR_REG_MAX);
      end
      `IMP_FORM_MPY_STO: begin
        // memory read value is taken before the store lands
        mul_a = src1_reg;
        mul_b = mem_a;
        legal = (src1_idx <= `IMP_PAR_REG_MAX) &&
                (src3_idx <= `IMP_PAR_REG_MAX) &&
                (dst_idx  <= `IMP_PAR_REG_MAX);
      end
      `IMP_FORM_NEGATE_WITH_BORROW: begin
        case (mode)
          `IMP_G_REG:      neg_src = src1_reg;
          `IMP_G_DIRECT:   neg_src = gen_direct;
          `IMP_G_INDIRECT: neg_src = mem_a;
          default:         neg_src = gen_immediate;
        endcase
        legal = (dst_idx <= `IMP_REG_MAX) &&
                (mode != `IMP_G_REG || src1_idx <= `IMP_REG_MAX);
      end
      default: legal = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  imp_mult24 u_imp_mult24 (
    .a   (mul_a),
    .b   (mul_b),
    .low (prod_low),
    .ovf (prod_ovf)
  );

  wire [32:0] sum_w;
  wire [32:0] dif_w;
  wire [32:0] negate_with_borrow_w;
  wire        sum_ovf;
  wire        dif_ovf;
  wire        negate_with_borrow_ovf;
  wire [31:0] prod_sat;
  wire [31:0] sum_res;
  wire [31:0] negate_with_borrow_res;
  wire [31:0] sat_pos;
  wire [31:0] sat_neg;
  assign sat_pos = 32'h7fff_ffff;
  assign sat_neg = 32'h8000_0000;
  // product and add/sub side evaluated in the same cycle
  assign sum_w   = {as_a[31], as_a} + {as_b[31], as_b};
  assign dif_w   = {as_a[31], as_a} - {as_b[31], as_b};
  assign negate_with_borrow_w  = 33'h0_0000_0000 - {neg_src[31], neg_src}
                   - {32'h0000_0000, carry_in};
  // unsigned view of the same subtraction yields the borrow
  wire [32:0] negate_with_borrow_bw;
  assign negate_with_borrow_bw = 33'h0_0000_0000 - {1'b0, neg_src}
                   - {32'h0000_0000, carry_in};
  assign sum_ovf  = sum_w[32] != sum_w[31];
  assign dif_ovf  = dif_w[32] != dif_w[31];
  assign negate_with_borrow_ovf = negate_with_borrow_w[32] != negate_with_borrow_w[31];
  // saturate toward the true sign when overflow mode is on
  assign prod_sat = (overflow_mode_bit && prod_ovf) ?
                    ((mul_a[23] ^ mul_b[23]) ? sat_neg : sat_pos) :
                    prod_low;
  wire [32:0] as_w;
  wire        as_ovf;
  assign as_w    = (form == `IMP_FORM_MPY_SUB) ? dif_w : sum_w;
  assign as_ovf  = (form == `IMP_FORM_MPY_SUB) ? dif_ovf : sum_ovf;
  assign sum_res = (overflow_mode_bit && as_ovf) ?
                   (as_w[32] ? sat_neg : sat_pos) : as_w[31:0];
  assign negate_with_borrow_res = (overflow_mode_bit && negate_with_borrow_ovf) ?
                    (negate_with_borrow_w[32] ? sat_neg : sat_pos) : negate_with_borrow_w[31:0];

  // ----------------------------------------------------------------
  // next state of result and status outputs
  // ----------------------------------------------------------------
  reg        next_wr1_en;
  reg [4:0]  next_wr1_idx;
  reg [31:0] next_wr1_data;
  reg        next_wr2_en;
  reg [4:0]  next_wr2_idx;
  reg        next_store_en;
  reg        next_n;
  reg        next_z;
  reg        next_v;
  reg        next_c;
  reg        any_ovf;
  always @* begin
    next_wr1_en   = 1'b0;
    next_wr1_idx  = dst_idx;
    next_wr1_data = prod_sat;
    next_wr2_en   = 1'b0;
    next_wr2_idx  = `IMP_SUM_DEST0;
    next_store_en = 1'b0;
    next_n        = 1'b0;
    next_z        = 1'b0;
    next_v        = 1'b0;
    next_c        = carry_in;
    any_ovf       = 1'b0;
    if (issue && legal) begin
      next_wr1_en = 1'b1;
      case (form)
        `IMP_FORM_MPY3, `IMP_FORM_MPY_STO: begin
          next_n        = prod_sat[31];
          next_z        = (prod_sat == 32'h0000_0000);
          next_v        = prod_ovf;
          any_ovf       = prod_ovf;
          next_store_en = (form == `IMP_FORM_MPY_STO);
        end
        `IMP_FORM_MPY_ADD, `IMP_FORM_MPY_SUB: begin
          next_wr1_idx = `IMP_PROD_DEST0 +
                         {4'h0, product_dest_select};
          next_wr2_en  = 1'b1;
          next_wr2_idx = `IMP_SUM_DEST0 +
                         {4'h0, sum_dest_select};
          next_v       = prod_ovf | as_ovf;
          any_ovf      = prod_ovf | as_ovf;
        end
        default: begin
          next_wr1_data = negate_with_borrow_res;
          next_n        = negate_with_borrow_res[31];
          next_z        = (negate_with_borrow_res == 32'h0000_0000);
          next_v        = negate_with_borrow_ovf;
          next_c        = negate_with_borrow_bw[32];
          any_ovf       = negate_with_borrow_ovf;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // single execute cycle register stage
  // ----------------------------------------------------------------
  // sources were sampled this cycle, writes appear at its end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr1_en                 <= 1'b0;
      wr1_idx                <= `IMP_RST_IDX;
      wr1_data               <= `IMP_RST_WORD;
      wr2_en                 <= 1'b0;
      wr2_idx                <= `IMP_RST_IDX;
      wr2_data               <= `IMP_RST_WORD;
      store_en               <= 1'b0;
      store_data             <= `IMP_RST_WORD;
      flags_valid            <= 1'b0;
      neg_flag               <= 1'b0;
      zero_flag              <= 1'b0;
      overflow_flag          <= 1'b0;
      carry_flag             <= 1'b0;
      underflow_flag         <= 1'b0;
      latched_overflow_flag  <= 1'b0;
      latched_underflow_flag <= 1'b0;
      bad_operands           <= 1'b0;
    end else begin
      wr1_en         <= next_wr1_en;
      wr1_idx        <= next_wr1_idx;
      wr1_data       <= next_wr1_data;
      wr2_en         <= next_wr2_en;
      wr2_idx        <= next_wr2_idx;
      wr2_data       <= sum_res;
      store_en       <= next_store_en;
      store_data     <= src3_reg;
      flags_valid    <= issue && legal;
      neg_flag       <= next_n;
      zero_flag      <= next_z;
      overflow_flag  <= next_v;
      carry_flag     <= next_c;
      underflow_flag <= 1'b0;
      latched_overflow_flag  <= latched_overflow_in |
                                any_ovf;
      latched_underflow_flag <= latched_underflow_in;
      bad_operands   <= issue && !legal;
    end
  end
endmodule // imp_datapath
`default_nettype wire

// file: hw/imp_mult24.v
`include "imp_defs.vh"
`default_nettype none
// signed 24x24 multiply, low word and overflow
module imp_mult24 (
  // operands
  input  wire [31:0] a,
  input  wire [31:0] b,
  // results
  output wire [31:0] low,
  output wire        ovf
);
  wire signed [47:0] sa;
  wire signed [47:0] sb;
  wire signed [47:0] prod;
  // sign-extend so the product is formed at full width
  assign sa   = {{24{a[`IMP_OPND_MSB]}}, a[`IMP_OPND_MSB:0]};
  assign sb   = {{24{b[`IMP_OPND_MSB]}}, b[`IMP_OPND_MSB:0]};
  // full signed product of low 24 bits
  assign prod = sa * sb;
  assign low  = prod[`IMP_RES_MSB:0];
  // upper 16 bits must all copy bit 31
  assign ovf  = (prod[`IMP_PROD_MSB:32] !=
                 {16{prod[`IMP_RES_MSB]}});
endmodule // imp_mult24
`default_nettype wire

// file: test/imp_cpu_model.sv
`default_nettype none
// register file and memory words behind the datapath
module imp_cpu_model (
  // clock and read indices
  input  wire logic        clk,
  input  wire logic [4:0]  src1_idx,
  input  wire logic [4:0]  src2_idx,
  input  wire logic [4:0]  src3_idx,
  input  wire logic [4:0]  src4_idx,
  // writes from the datapath
  input  wire logic        wr1_en,
  input  wire logic [4:0]  wr1_idx,
  input  wire logic [31:0] wr1_data,
  input  wire logic        wr2_en,
  input  wire logic [4:0]  wr2_idx,
  input  wire logic [31:0] wr2_data,
  input  wire logic        store_en,
  input  wire logic [31:0] store_data,
  // operands
  output logic      [31:0] src1_reg,
  output logic      [31:0] src2_reg,
  output logic      [31:0] src3_reg,
  output logic      [31:0] src4_reg,
  output logic      [31:0] mem_a,
  output logic      [31:0] mem_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rf [0:31];
  logic [31:0] mem_lo;
  logic [31:0] mem_hi;
  // registers read before any write of the cycle
  assign src1_reg = rf[src1_idx];
  assign src2_reg = rf[src2_idx];
  assign src3_reg = rf[src3_idx];
  assign src4_reg = rf[src4_idx];
  assign mem_a = mem_lo;
  assign mem_b = mem_hi;
  // results land one clock after the datapath registers them; store hits mem_a's word
  always @(posedge clk) begin
    if (wr1_en) rf[wr1_idx] <= wr1_data;
    if (wr2_en) rf[wr2_idx] <= wr2_data;
    if (store_en) mem_lo <= store_data;
  end
endmodule // imp_cpu_model
`default_nettype wire

// file: test/imp_datapath_props.sv
`include "imp_defs.vh"
`default_nettype none
// checker on the multiply datapath ports
module imp_datapath_props (
  // clock, reset and issue
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        issue,
  input wire logic [2:0]  form,
  input wire logic [1:0]  mode,
  input wire logic [4:0]  dst_idx,
  input wire logic [4:0]  src1_idx,
  input wire logic [4:0]  src2_idx,
  input wire logic [31:0] src1_reg,
  input wire logic [31:0] src2_reg,
  input wire logic [31:0] src3_reg,
  input wire logic        overflow_mode_bit,
  input wire logic        carry_in,
  input wire logic        latched_overflow_in,
  input wire logic        latched_underflow_in,
  // results
  input wire logic        wr1_en,
  input wire logic [31:0] wr1_data,
  input wire logic        wr2_en,
  input wire logic        store_en,
  input wire logic [31:0] store_data,
  input wire logic        flags_valid,
  input wire logic        neg_flag,
  input wire logic        zero_flag,
  input wire logic        overflow_flag,
  input wire logic        carry_flag,
  input wire logic        underflow_flag,
  input wire logic        latched_overflow_flag,
  input wire logic        latched_underflow_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [47:0] prod;
  logic        mpy_rr;
  logic        ovf_e;
  // --------------------------------------------
  // reference product of the register operands
  // --------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) prod <= 48'h0;
    else prod <= {{24{src1_reg[23]}}, src1_reg[23:0]}
      * {{24{src2_reg[23]}}, src2_reg[23:0]};
  // legal register-register plain multiply
  assign mpy_rr = issue && form == `IMP_FORM_MPY3 && mode == 2'h0
    && dst_idx <= 5'h1b && src1_idx <= 5'h1b && src2_idx <= 5'h1b;
  assign ovf_e = prod[47:32] != {16{prod[31]}};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_low_word: assert property (
    mpy_rr && !overflow_mode_bit |=> wr1_en && wr1_data == prod[31:0])
    else $error("multiply low word wrong");
  a_ovf_detect: assert property (
    mpy_rr |=> overflow_flag == ovf_e && !underflow_flag)
    else $error("overflow flag wrong");
  a_ovm_saturate: assert property (
    mpy_rr && overflow_mode_bit |=> !ovf_e
      || wr1_data == (prod[47] ? 32'h8000_0000 : 32'h7fff_ffff))
    else $error("overflow mode result wrong");
  a_sign_zero: assert property (
    mpy_rr |=> neg_flag == wr1_data[31] && zero_flag == (wr1_data == 0))
    else $error("sign or zero flag wrong");
  a_carry_kept: assert property (
    issue && form != `IMP_FORM_NEGATE_WITH_BORROW |=> carry_flag == $past(carry_in))
    else $error("carry changed");
  a_latch_flags: assert property (
    flags_valid |-> latched_underflow_flag == $past(latched_underflow_in)
      && latched_overflow_flag
        == ($past(latched_overflow_in) || overflow_flag))
    else $error("latched flags wrong");
  a_idle_quiet: assert property (
    !issue |=> !wr1_en && !wr2_en && !store_en && !flags_valid)
    else $error("output without issue");
  a_store_pair: assert property (
    issue && form == `IMP_FORM_MPY_STO |=> store_en == wr1_en
      && (!store_en || store_data == $past(src3_reg)))
    else $error("store pairing wrong");
  a_par_pair: assert property (
    issue && form inside {`IMP_FORM_MPY_ADD, `IMP_FORM_MPY_SUB}
      |=> wr1_en == wr2_en)
    else $error("parallel writes unpaired");
  c_ovf: cover property (mpy_rr ##1 overflow_flag);
  c_par: cover property (issue && form == `IMP_FORM_MPY_ADD ##1 wr2_en);
  c_sto: cover property (store_en);
endmodule // imp_datapath_props
`default_nettype wire

// file: test/integer_multiply_parallel_ops_tb.sv
`include "imp_defs.vh"
`default_nettype none
module integer_multiply_parallel_ops_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, issue = 0, overflow_mode_bit = 0, carry_in = 0;
  logic product_dest_select = 0, sum_dest_select = 0;
  logic latched_overflow_in = 0, latched_underflow_in = 0;
  logic [2:0] form = 0;
  logic [1:0] mode = 0;
  logic [4:0] dst_idx = 0, src1_idx = 0, src2_idx = 0;
  logic [4:0] src3_idx = 0, src4_idx = 0, wr1_idx, wr2_idx;
  logic [31:0] gen_direct = 0, gen_immediate = 0, mem_a, mem_b;
  logic [31:0] src1_reg, src2_reg, src3_reg, src4_reg;
  logic [31:0] wr1_data, wr2_data, store_data;
  logic wr1_en, wr2_en, store_en, flags_valid, neg_flag, zero_flag;
  logic overflow_flag, carry_flag, underflow_flag, bad_operands;
  logic latched_overflow_flag, latched_underflow_flag;
  int error_cnt = 0, n_compared = 0;
  imp_datapath u_imp_datapath (.*);
  imp_cpu_model u_imp_cpu_model (.*);
  always #2.5 clk = ~clk;
  // ----------------------------------
  // shared tasks
  // ----------------------------------
  task automatic run(input logic [2:0] f, input logic [1:0] m);
    @(posedge clk);
    #1 form = f;
    mode = m;
    issue = 1'b1;
    @(posedge clk);
    #1 issue = 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d, compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------
  // scenarios
  // ----------------------------------
  task automatic t_mpy3;
    logic [31:0] e [4] = '{32'h15, 32'h23, 32'h21, 32'h37};
    u_imp_cpu_model.rf[1] = 32'h7700_0003;
    u_imp_cpu_model.rf[2] = 32'h7;
    u_imp_cpu_model.mem_lo = 32'h5;
    u_imp_cpu_model.mem_hi = 32'hb;
    {src1_idx, src2_idx, dst_idx} = {5'h1, 5'h2, 5'h5};
    {carry_in, latched_overflow_in, latched_underflow_in} = 3'h7;
    for (int m = 0; m < 4; m++) begin
      run(`IMP_FORM_MPY3, m[1:0]);
      chk(wr1_data, e[m]);
      chk(32'({flags_valid, neg_flag, zero_flag, overflow_flag, carry_flag,
        underflow_flag, latched_overflow_flag, latched_underflow_flag}),
        32'h8b);
    end
    u_imp_cpu_model.rf[1] = 32'h0033_c251;
    u_imp_cpu_model.rf[2] = 32'h0078_b600;
    latched_overflow_in = 1'b0;
    run(`IMP_FORM_MPY3, 2'h0);
    chk(wr1_data, 32'he21d_9600);
    chk(32'({neg_flag, overflow_flag, latched_overflow_flag}),
      32'h7);
    overflow_mode_bit = 1'b1;
    run(`IMP_FORM_MPY3, 2'h0);
    chk(wr1_data, 32'h7fff_ffff);
    u_imp_cpu_model.rf[2] = 32'h0080_0000;
    run(`IMP_FORM_MPY3, 2'h0);
    chk(wr1_data, 32'h8000_0000);
    overflow_mode_bit = 1'b0;
    u_imp_cpu_model.rf[1] = 32'h00ff_fffe;
    u_imp_cpu_model.rf[2] = 32'h3;
    run(`IMP_FORM_MPY3, 2'h0);
    chk(wr1_data, 32'hffff_fffa);
    chk(32'({neg_flag, zero_flag, overflow_flag}), 32'h4);
  endtask
  task automatic t_par;
    logic [31:0] p [4] = '{32'h23, 32'h0a, 32'h06, 32'h0a};
    logic [31:0] s [8] = '{32'h5, 32'ha, 32'hc, 32'ha,
      32'hffff_ffff, 32'h4, 32'hffff_fffe, 32'hffff_fffc};
    {src1_idx, src2_idx} = {5'h0, 5'h1};
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      #1 u_imp_cpu_model.rf[0] = 32'h2;
      u_imp_cpu_model.rf[1] = 32'h3;
      u_imp_cpu_model.mem_lo = 32'h5;
      u_imp_cpu_model.mem_hi = 32'h7;
      product_dest_select = k[0];
      sum_dest_select = ~k[0];
      run(k[2] ? `IMP_FORM_MPY_SUB : `IMP_FORM_MPY_ADD, k[1:0]);
      chk(wr1_data, p[k[1:0]]);
      chk(wr2_data, s[k]);
      chk(32'({wr1_idx, wr2_idx}), 32'({4'h0, k[0], 4'h1, ~k[0]}));
    end
  endtask
  task automatic t_store;
    @(posedge clk);
    #1 u_imp_cpu_model.rf[3] = 32'h9;
    u_imp_cpu_model.rf[4] = 32'h42;
    u_imp_cpu_model.mem_lo = 32'h6;
    {src1_idx, src3_idx, dst_idx} = {5'h3, 5'h4, 5'h7};
    run(`IMP_FORM_MPY_STO, 2'h0);
    chk(wr1_data, 32'h36);
    chk(32'({store_en, wr1_en, wr1_idx}), 32'h67);
    chk(store_data, 32'h42);
    @(posedge clk);
    #1 chk(mem_a, 32'h42);
  endtask
  task automatic t_negate_with_borrow;
    logic [31:0] v [4] = '{32'h5, 32'h20, 32'h100, 32'hae};
    u_imp_cpu_model.rf[6] = v[0];
    u_imp_cpu_model.mem_lo = v[2];
    {gen_direct, gen_immediate} = {v[1], v[3]};
    {src1_idx, dst_idx} = {5'h6, 5'h9};
    for (int k = 0; k < 8; k++) begin
      carry_in = k[2];
      run(`IMP_FORM_NEGATE_WITH_BORROW, k[1:0]);
      chk(wr1_data, 32'h0 - v[k[1:0]] - 32'(k[2]));
    end
    u_imp_cpu_model.rf[6] = 32'hffff_ffcb;
    run(`IMP_FORM_NEGATE_WITH_BORROW, 2'h0);
    chk(wr1_data, 32'h34);
    chk(32'({carry_flag, neg_flag, zero_flag}), 32'h4);
    u_imp_cpu_model.rf[6] = 32'h0;
    carry_in = 1'b0;
    run(`IMP_FORM_NEGATE_WITH_BORROW, 2'h0);
    chk(wr1_data, 32'h0);
    chk(32'({carry_flag, neg_flag, zero_flag}), 32'h1);
  endtask
  task automatic t_bad;
    {src1_idx, src2_idx, dst_idx} = {5'h1, 5'h2, 5'h1c};
    run(`IMP_FORM_MPY3, 2'h0);
    chk(32'({wr1_en, bad_operands}), 32'h1);
    dst_idx = 5'h1b;
    run(`IMP_FORM_MPY3, 2'h0);
    chk(32'({wr1_en, bad_operands}), 32'h2);
    src1_idx = 5'h8;
    run(`IMP_FORM_MPY_ADD, 2'h0);
    chk(32'({wr1_en, wr2_en, bad_operands}), 32'h1);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    t_mpy3;
    t_par;
    t_store;
    t_negate_with_borrow;
    t_bad;
    conclude;
  end
  // watchdog
  initial begin
    #5000;
    error_cnt++;
    conclude;
  end
endmodule // integer_multiply_parallel_ops_tb
bind imp_datapath imp_datapath_props u_imp_datapath_props (.*);
`default_nettype wire
